// ---- pkg/ica_pkg.sv ----
// Package of constants and types for the I/O channel adapter interface.
package ica_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] WDATA_OFS   = 8'h08;
  localparam logic [7:0] RDATA_OFS   = 8'h0c;
  localparam logic [7:0] MEMBASE_OFS = 8'h10;
  localparam logic [7:0] IOBASE_OFS  = 8'h14;

  // ---------------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------------
  localparam int CTRL_WS_LSB    = 0;   // Three-bit wait-state jumper code.
  localparam int CTRL_HIMEM_BIT = 3;   // One selects all-memory strobes.
  localparam int CTRL_WEDGE_BIT = 4;   // One captures on strobe release.
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [3:0]  MEMBASE_RST = 4'h0;
  localparam logic [6:0]  HIBASE_RST  = 7'h00;
  localparam logic [15:0] IOBASE_RST  = 16'h0300;
  localparam logic [15:0] IOMASK      = 16'hfff0;

  // ---------------------------------------------------------------------
  // Strobe timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ    = 50;
  localparam int WS_NS      = 167;  // One host wait state beyond the first.
  localparam int BASE16_NS  = 250;
  localparam int BASE8_NS   = 750;
  localparam int WS_CYC     = (WS_NS * CLK_MHZ) / 1000;
  localparam int BASE16_CYC = (BASE16_NS * CLK_MHZ) / 1000;
  localparam int BASE8_CYC  = (BASE8_NS * CLK_MHZ) / 1000;
  localparam int WS_W       = 3;
  localparam logic [WS_W-1:0] WS16_DEF = 3'd1;
  localparam logic [WS_W-1:0] WS8_DEF  = 3'd4;
  localparam logic [WS_W-1:0] WS_MAX   = 3'd5;
  localparam int CNT_W      = 8;

  // ---------------------------------------------------------------------
  // Bus slave answers
  // ---------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ICA_IDLE,
    ICA_WAIT,
    ICA_DONE
  } ica_ws_state_t;

endpackage

// ---- rtl/ica_wait_gen.sv ----
// Wait-state generator that stretches decoded I/O strobes.
`timescale 1ns/1ps

module ica_wait_gen (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Strobe and selection
  input  wire logic                     strobe_sel,
  input  wire logic                     width16,
  input  wire logic [ica_pkg::WS_W-1:0] ws_code,
  // Status
  output logic                          chan_ready,
  output logic                          stretching
);

  ica_pkg::ica_ws_state_t state_q;
  logic [ica_pkg::CNT_W-1:0] cnt_q;
  logic [ica_pkg::CNT_W-1:0] limit;
  logic [ica_pkg::WS_W-1:0]  ws_eff;

  // The 8-bit path never drops below four states; codes above five clamp.
  always_comb begin
    ws_eff = ws_code;
    if (ws_code > ica_pkg::WS_MAX) begin
      ws_eff = ica_pkg::WS_MAX;
    end
    if (!width16 && ws_eff < ica_pkg::WS8_DEF) begin // RL9
      ws_eff = ica_pkg::WS8_DEF;
    end
    if (width16 && ws_eff == 3'd0) begin // RL8
      ws_eff = ica_pkg::WS16_DEF;
    end
    // Worked in nanoseconds first, so four states reach the full 750 ns
    // count rather than a sum of separately rounded cycle figures.
    limit = ica_pkg::CNT_W'((ica_pkg::BASE16_NS
            + (int'(ws_eff) - 1) * ica_pkg::WS_NS)
            * ica_pkg::CLK_MHZ / 1000);
  end

  // Count from decode until the chosen strobe length has elapsed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ica_pkg::ICA_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ica_pkg::ICA_IDLE: begin
          cnt_q <= '0;
          if (strobe_sel) begin
            state_q <= ica_pkg::ICA_WAIT; // RL11
          end
        end
        ica_pkg::ICA_WAIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (!strobe_sel) begin
            state_q <= ica_pkg::ICA_IDLE;
          end else if (cnt_q + 1'b1 >= limit) begin
            state_q <= ica_pkg::ICA_DONE; // RL7
          end
        end
        ica_pkg::ICA_DONE: begin
          if (!strobe_sel) begin
            state_q <= ica_pkg::ICA_IDLE;
          end
        end
      endcase
    end
  end

  // Ready is held low while a selected strobe is still being counted.
  assign chan_ready = !(strobe_sel && state_q != ica_pkg::ICA_DONE); // RL11
  assign stretching = (state_q == ica_pkg::ICA_WAIT);

  a_ready_low_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ica_pkg::ICA_WAIT && strobe_sel |-> !chan_ready) // RL11
    else $error("Channel ready released during wait count.");
  a_wait_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(strobe_sel) |-> ##[1:60] (chan_ready || !strobe_sel)) // RL7
    else $error("Wait count never completed.");
  a_eight_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    !width16 |-> limit >= ica_pkg::CNT_W'(ica_pkg::BASE8_CYC)) // RL9
    else $error("Eight-bit strobe shorter than four wait states.");
  c_stretch_done: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ica_pkg::ICA_WAIT ##1 state_q == ica_pkg::ICA_DONE);

endmodule // ica_wait_gen

// ---- rtl/ica_adapter.sv ----
// Top of the I/O channel adapter interface with its AXI4-Lite registers.
`timescale 1ns/1ps

// Summary of operation
// (RL1) The host raises low-meg memory strobes only when bits 20 to 23 are 0.
// (RL2) Low-meg strobes are used without any check of address bits 20 to 23.
// (RL3) The host raises the all-memory strobes for every memory access.
// (RL4) All-memory strobes are qualified by our decode of bits 20 to 23.
// (RL5) Bits 17 to 23 are decoded and held in a latch opened by ALE.
// (RL6) Only the low byte moves without the width jumper, 16 bits with it.
// (RL7) Slow accesses stretch both I/O read and write strobes.
// (RL8) A 16-bit design defaults to one wait state, jumpers give 2 to 5.
// (RL9) An 8-bit design defaults to four wait states, one jumper gives 5.
// (RL10) Write data is taken at strobe assertion or at release, selectable.
// (RL11) Wait counting starts at decode and holds ready low until done.
module ica_adapter (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Expansion channel pins
  input  wire logic [19:0] latched_low_address,
  input  wire logic [6:0]  unlatched_high_address,
  input  wire logic        address_latch_enable,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic        low_meg_mem_read_strobe_n,
  input  wire logic        low_meg_mem_write_strobe_n,
  input  wire logic        any_mem_read_strobe_n,
  input  wire logic        any_mem_write_strobe_n,
  input  wire logic        width_select_jumper,
  input  wire logic [15:0] data_in,
  output logic [15:0]      data_out,
  output logic             data_oe_n,
  output logic             chan_ready_q,
  output logic             mem_select_q
);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  localparam int NS = 51;
  logic [NS-1:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {data_in, latched_low_address, unlatched_high_address,
                    address_latch_enable, io_read_strobe_n,
                    io_write_strobe_n, low_meg_mem_read_strobe_n,
                    low_meg_mem_write_strobe_n, any_mem_read_strobe_n,
                    any_mem_write_strobe_n, width_select_jumper};

  // Two flops per pin; the first stage feeds only the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '1;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // Data goes through the same two stages, so it stays aligned with the
  // strobes that capture it.
  logic [15:0] din;
  logic [19:0] sa;
  logic [6:0]  la;
  logic ale, io_read_strobe, io_write_strobe, smr, smw, mr, mw, wide;
  assign din  = sync2_q[50:35];
  assign sa   = sync2_q[34:15];
  assign la   = sync2_q[14:8];
  assign ale  = sync2_q[7];
  assign io_read_strobe  = !sync2_q[6];
  assign io_write_strobe  = !sync2_q[5];
  assign smr  = !sync2_q[4];
  assign smw  = !sync2_q[3];
  assign mr   = !sync2_q[2];
  assign mw   = !sync2_q[1];
  assign wide = sync2_q[0]; // RL6

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] wdata_q, rdata_q, iobase_q;
  logic [3:0]  membase_q;
  logic [6:0]  hibase_q;
  logic        wr_seen_q;
  logic [7:0]  aw_q, ar_q;
  logic        aw_have_q, w_have_q, rd_fire;
  logic [31:0] wd_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb ar_q = s_axi_araddr;

  // High address decodes follow the pins while ALE is high and freeze when
  // it falls, so the select outlives the high lines going invalid. Bits
  // 17 to 19 serve both strobe sets; bits 20 to 23 only the all-memory set.
  logic hi_latch_q, mid_latch_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_latch_q  <= 1'b0;
      mid_latch_q <= 1'b0;
    end else if (ale) begin
      hi_latch_q  <= (la[6:3] == membase_q); // RL5
      mid_latch_q <= (la[2:0] == hibase_q[2:0]); // RL5
    end
  end

  // Memory select: low-meg strobes skip the decode of bits 20 to 23.
  localparam logic [15:0] IOMASK_L = ica_pkg::IOMASK;
  logic low_hit, any_hit, io_sel;
  assign low_hit = (smr || smw) && mid_latch_q; // RL2
  assign any_hit = (mr || mw) && hi_latch_q && mid_latch_q; // RL4
  assign io_sel  = (io_read_strobe || io_write_strobe) && ((sa[15:0] & IOMASK_L) == iobase_q);

  logic ws_ready, ws_busy;
  ica_wait_gen u_wait (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .strobe_sel (io_sel),
    .width16    (wide),
    .ws_code    (ctrl_q[ica_pkg::CTRL_WS_LSB +: ica_pkg::WS_W]),
    .chan_ready (ws_ready),
    .stretching (ws_busy)
  );

  // Registered pin outputs; data is masked to the active width.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_ready_q <= 1'b1;
      mem_select_q <= 1'b0;
      data_out     <= '0;
      data_oe_n    <= 1'b1;
    end else begin
      chan_ready_q <= ws_ready; // RL11
      mem_select_q <= ctrl_q[ica_pkg::CTRL_HIMEM_BIT] ? any_hit
                                                      : low_hit;
      data_out     <= wide ? rdata_q : {8'h00, rdata_q[7:0]}; // RL6
      data_oe_n    <= !(io_read_strobe && io_sel);
    end
  end

  // Write capture on strobe assertion or release, chosen by control.
  logic iow_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iow_q     <= 1'b0;
      wdata_q   <= '0;
      wr_seen_q <= 1'b0;
    end else begin
      iow_q <= io_write_strobe && io_sel;
      if (ctrl_q[ica_pkg::CTRL_WEDGE_BIT] ? (iow_q && !(io_write_strobe && io_sel))
                                          : (!iow_q && io_write_strobe && io_sel)) begin
        wdata_q   <= wide ? din : {8'h00, din[7:0]}; // RL10
        wr_seen_q <= 1'b1;
      end else if (rd_fire && ar_q == ica_pkg::WDATA_OFS) begin
        wr_seen_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------
  // Address and data are taken in either order; response after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ica_pkg::RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= '0;
      wd_q          <= '0;
      ctrl_q        <= ica_pkg::CTRL_RST;
      rdata_q       <= '0;
      membase_q     <= ica_pkg::MEMBASE_RST;
      hibase_q      <= ica_pkg::HIBASE_RST;
      iobase_q      <= ica_pkg::IOBASE_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ica_pkg::RESP_OKAY;
        unique case (aw_q)
          ica_pkg::CTRL_OFS:    ctrl_q    <= wd_q;
          ica_pkg::RDATA_OFS:   rdata_q   <= wd_q[15:0];
          ica_pkg::MEMBASE_OFS: begin
            membase_q <= wd_q[3:0];
            hibase_q  <= wd_q[14:8];
          end
          ica_pkg::IOBASE_OFS:  iobase_q  <= wd_q[15:0];
          default:              s_axi_bresp <= ica_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address; status shows live state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= ica_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= ica_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          ica_pkg::CTRL_OFS:    s_axi_rdata <= ctrl_q;
          ica_pkg::STATUS_OFS:  s_axi_rdata <= {25'h0, wr_seen_q, ws_busy,
                                  hi_latch_q, wide, ws_ready, io_read_strobe, io_write_strobe};
          ica_pkg::WDATA_OFS:   s_axi_rdata <= {16'h0, wdata_q};
          ica_pkg::RDATA_OFS:   s_axi_rdata <= {16'h0, rdata_q};
          ica_pkg::MEMBASE_OFS: s_axi_rdata <= {17'h0, hibase_q,
                                                4'h0, membase_q};
          ica_pkg::IOBASE_OFS:  s_axi_rdata <= {16'h0, iobase_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= ica_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  a_narrow_data: assert property (@(posedge aclk) disable iff (!aresetn)
    !wide ##1 !$past(wide) |-> data_out[15:8] == 8'h00) // RL6
    else $error("Upper byte driven in 8-bit mode.");
  a_low_meg_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[3] && low_hit |=> mem_select_q) // RL2
    else $error("Low-meg strobe did not select memory.");
  a_high_qualify: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[3] && !hi_latch_q && $stable(ctrl_q) |=> !mem_select_q) // RL4
    else $error("All-memory select without high decode.");
  a_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !ale |=> $stable(hi_latch_q)) // RL5
    else $error("High decode changed while latch closed.");
  a_ready_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    !ws_ready |=> !chan_ready_q) // RL11
    else $error("Ready pin not following wait generator.");
  a_resp_order: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_bvalid) |-> $past(aw_have_q && w_have_q)) // write response waits for address and data
    else $error("Write response before address and data.");
  c_io_read: cover property (@(posedge aclk) disable iff (!aresetn)
    !data_oe_n);
  c_wr_capture: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(wr_seen_q));
  c_himem: cover property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[3] && mem_select_q);

endmodule // ica_adapter

// ---- tb/ica_host_model.sv ----
// Host-side model of the expansion channel that runs I/O and memory cycles.
`timescale 1ns/1ps

module ica_host_model (
  // Clock
  input  wire logic        aclk,
  // Adapter answers
  input  wire logic        chan_ready_q,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_n,
  input  wire logic        mem_select_q,
  // Channel lines driven by the host
  output logic [19:0]      latched_low_address,
  output logic [6:0]       unlatched_high_address,
  output logic             address_latch_enable,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic             low_meg_mem_read_strobe_n,
  output logic             low_meg_mem_write_strobe_n,
  output logic             any_mem_read_strobe_n,
  output logic             any_mem_write_strobe_n,
  output logic [15:0]      data_in
);
  // Idle channel: strobes inactive, buses show a pattern, not a stale value.
  initial begin
    latched_low_address        = 20'h5a5a5;
    unlatched_high_address     = 7'h2a;
    address_latch_enable       = 1'b0;
    io_read_strobe_n           = 1'b1;
    io_write_strobe_n          = 1'b1;
    low_meg_mem_read_strobe_n  = 1'b1;
    low_meg_mem_write_strobe_n = 1'b1;
    any_mem_read_strobe_n      = 1'b1;
    any_mem_write_strobe_n     = 1'b1;
    data_in                    = 16'h3c3c;
  end

  // Address phase: one latch-enable pulse with both address groups valid.
  task automatic addr_phase(input logic [23:0] a);
    @(posedge aclk);
    latched_low_address    <= a[19:0];
    unlatched_high_address <= a[23:17];
    address_latch_enable   <= 1'b1;
    @(posedge aclk);
    address_latch_enable   <= 1'b0;
  endtask

  // I/O cycle: the host gives its default strobe time, then waits on ready.
  task automatic io_cycle(input logic wr, input logic [15:0] a,
                          input logic [15:0] d, input logic wide,
                          output int n, output logic [15:0] rd,
                          output logic oe);
    int base;
    base = wide ? ica_pkg::BASE16_CYC + 1 : ica_pkg::BASE8_CYC + 1;
    n = 0;
    rd = 16'h0000;
    oe = 1'b0;
    addr_phase({8'h00, a});
    // A narrow host leaves the upper byte undriven, so it shows junk.
    data_in <= wide ? d : {~d[15:8], d[7:0]};
    @(posedge aclk);
    io_write_strobe_n <= !wr;
    io_read_strobe_n  <= wr;
    while ((n < base || chan_ready_q !== 1'b1) && n < 400) begin
      @(posedge aclk);
      n++;
      if (data_oe_n === 1'b0) begin
        oe = 1'b1;
        rd = data_out;
      end
    end
    io_read_strobe_n  <= 1'b1;
    io_write_strobe_n <= 1'b1;
    repeat (3) @(posedge aclk);
    data_in             <= ~data_in;
    latched_low_address <= ~latched_low_address;
  endtask

  // Memory cycle; the high address lines go invalid before the strobe ends.
  task automatic mem_cycle(input logic wr, input logic [23:0] a,
                           output logic sel);
    addr_phase(a);
    @(posedge aclk);
    any_mem_write_strobe_n <= !wr;
    any_mem_read_strobe_n  <= wr;
    if (a[23:20] == 4'h0) begin
      low_meg_mem_write_strobe_n <= !wr;
      low_meg_mem_read_strobe_n  <= wr;
    end
    repeat (6) @(posedge aclk);
    unlatched_high_address <= ~a[23:17];
    repeat (6) @(posedge aclk);
    sel = mem_select_q;
    any_mem_write_strobe_n     <= 1'b1;
    any_mem_read_strobe_n      <= 1'b1;
    low_meg_mem_write_strobe_n <= 1'b1;
    low_meg_mem_read_strobe_n  <= 1'b1;
    repeat (3) @(posedge aclk);
    latched_low_address <= ~latched_low_address;
  endtask
endmodule // ica_host_model

// ---- tb/ica_adapter_bench.sv ----
// Self-checking bench for the I/O channel adapter interface.
`timescale 1ns/1ps

module ica_adapter_bench;
  localparam logic [1:0] OK  = ica_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = ica_pkg::RESP_SLVERR;

  logic        aclk, aresetn, width_select_jumper;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [19:0] latched_low_address;
  logic [6:0]  unlatched_high_address;
  logic        address_latch_enable, io_read_strobe_n, io_write_strobe_n;
  logic        low_meg_mem_read_strobe_n, low_meg_mem_write_strobe_n;
  logic        any_mem_read_strobe_n, any_mem_write_strobe_n;
  logic [15:0] data_in, data_out;
  logic        data_oe_n, chan_ready_q, mem_select_q;
  int          n_mismatch, check_count;

  ica_adapter    i_dut (.*);
  ica_host_model i_host (.*);

  // --------------------------------------------------------------------
  // Clock, reset and checking helpers
  // --------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi,
                             input int got);
    check_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A wait that runs out ends the run, since the bus is then stuck.
  task automatic give_up(input int n);
    if (n >= 200) begin
      n_mismatch++;
      $display("mismatch bus answer expected in 200 cycles seen none");
      finish_test();
    end
  endtask

  // Register write: address and data offered together, each dropped on take.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    give_up(n);
    check_val("write response", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  // Register read: data and response are taken at the rvalid edge.
  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    give_up(n);
    check_val("read response", {30'h0, er}, {30'h0, s_axi_rresp});
    check_val("read data", exp, s_axi_rdata);
  endtask

  // One width and wait code: host write then host read, both stretched.
  task automatic io_test(input logic wide, input int code, input logic eb);
    int lim, n, ws;
    logic [15:0] m, rd;
    logic oe;
    m = wide ? 16'hffff : 16'h00ff;
    ws = (code == 0) ? 1 : code;
    if (!wide && ws < int'(ica_pkg::WS8_DEF)) ws = int'(ica_pkg::WS8_DEF);
    lim = ((ica_pkg::BASE16_NS + (ws - 1) * ica_pkg::WS_NS)
          * ica_pkg::CLK_MHZ) / 1000;
    width_select_jumper <= wide;
    axi_write(ica_pkg::CTRL_OFS, 32'(code) | (32'(eb) << 4), OK);
    axi_write(ica_pkg::RDATA_OFS, 32'h0000_c3a5, OK);
    i_host.io_cycle(1'b1, 16'h0305, 16'ha55a, wide, n, rd, oe);
    check_range("write stretch", lim, lim + 6, n);
    axi_read(ica_pkg::WDATA_OFS, {16'h0, 16'ha55a & m}, OK);
    i_host.io_cycle(1'b0, 16'h030c, 16'h0000, wide, n, rd, oe);
    check_range("read stretch", lim, lim + 6, n);
    check_val("read drive", 32'h1, {31'h0, oe});
    check_val("host read data", {16'h0, 16'hc3a5 & m}, {16'h0, rd});
  endtask

  task automatic mem_check(input logic wr, input logic [23:0] a,
                           input logic exp);
    logic s;
    i_host.mem_cycle(wr, a, s);
    check_val("memory select", {31'h0, exp}, {31'h0, s});
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    int n;
    logic [15:0] rd;
    logic oe;
    aresetn = 1'b0;
    width_select_jumper = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and the refusal of an unmapped word.
    axi_read(ica_pkg::CTRL_OFS, ica_pkg::CTRL_RST, OK);
    axi_read(ica_pkg::IOBASE_OFS, {16'h0, ica_pkg::IOBASE_RST}, OK);
    axi_read(ica_pkg::MEMBASE_OFS, 32'h0, OK);
    axi_read(8'h40, 32'h0, ERR);
    axi_write(8'h40, 32'hffff_ffff, ERR);
    check_val("idle ready", 32'h1, {31'h0, chan_ready_q});
    // Wait codes 0 to 5 in both widths, capture edge alternating.
    for (int w = 0; w < 2; w++) begin
      for (int c = 0; c < 6; c++) begin
        io_test(w[0], c, c[0]);
      end
    end
    // An address outside the window is neither stretched nor captured.
    axi_write(ica_pkg::CTRL_OFS, 32'h0000_0002, OK);
    i_host.io_cycle(1'b1, 16'h0310, 16'h1111, 1'b1, n, rd, oe);
    check_range("unselected strobe", 13, 13, n);
    axi_read(ica_pkg::WDATA_OFS, 32'h0000_a55a, OK);
    // A moved window selects its new address.
    axi_write(ica_pkg::IOBASE_OFS, 32'h0000_0280, OK);
    i_host.io_cycle(1'b1, 16'h0283, 16'h6b29, 1'b1, n, rd, oe);
    check_range("moved window", 20, 26, n);
    axi_read(ica_pkg::WDATA_OFS, 32'h0000_6b29, OK);
    // First-megabyte strobes: bits 17 to 19 decide, latched by ALE.
    axi_write(ica_pkg::MEMBASE_OFS, 32'h0000_0500, OK);
    axi_write(ica_pkg::CTRL_OFS, 32'h0000_0000, OK);
    mem_check(1'b0, 24'h0a1234, 1'b1);
    mem_check(1'b0, 24'h0c1234, 1'b0);
    // All-memory strobes: bits 20 to 23 must match the assigned range.
    axi_write(ica_pkg::MEMBASE_OFS, 32'h0000_1d03, OK);
    axi_write(ica_pkg::CTRL_OFS, 32'h0000_0008, OK);
    mem_check(1'b1, 24'h3a1234, 1'b1);
    mem_check(1'b0, 24'h5a1234, 1'b0);
    finish_test();
  end
endmodule // ica_adapter_bench
